// [return_and_rotate_exec_tb_top.sv]
// testbench: drives the return and rotate execution block through its own ports
`timescale 1ns/1ps
module return_and_rotate_exec_tb_top;
  logic                       CLK_IN = 1'b0;               // core clock
  logic                       SYS_RST_IN = 1'b1;           // held for 20 clocks
  logic                       INSTR_VALID_IN = 1'b0;       // instruction offer
  logic [15:0]                INSTR_IN = 16'h0000;         // instruction word
  logic                       INSTR_READY_OUT;
  logic [rre_pkg::PC_W-1:0]   STACK_TOP_IN = '0;           // stack top seen by core
  logic                       STACK_POP_OUT;
  logic                       PC_LOAD_OUT;
  logic [rre_pkg::PC_W-1:0]   PC_OUT;
  logic                       GLOBAL_HIGH_INT_ENABLE_OUT;
  logic                       PERIPHERAL_LOW_INT_ENABLE_OUT;
  logic [rre_pkg::BUS_AW-1:0] BUS_ADDR_IN = '0;            // register bus
  logic [7:0]                 BUS_WDATA_IN = 8'h00;
  logic                       BUS_WR_IN = 1'b0;
  logic                       BUS_RD_IN = 1'b0;
  logic [7:0]                 BUS_RDATA_OUT;
  int                         n_mismatch = 0;              // failed compares
  int                         checks_done = 0;             // all compares

  rre_exec dut_u (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
    .INSTR_IN(INSTR_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .STACK_TOP_IN(STACK_TOP_IN),
    .STACK_POP_OUT(STACK_POP_OUT), .PC_LOAD_OUT(PC_LOAD_OUT), .PC_OUT(PC_OUT),
    .GLOBAL_HIGH_INT_ENABLE_OUT(GLOBAL_HIGH_INT_ENABLE_OUT),
    .PERIPHERAL_LOW_INT_ENABLE_OUT(PERIPHERAL_LOW_INT_ENABLE_OUT), .BUS_ADDR_IN(BUS_ADDR_IN),
    .BUS_WDATA_IN(BUS_WDATA_IN), .BUS_WR_IN(BUS_WR_IN), .BUS_RD_IN(BUS_RD_IN),
    .BUS_RDATA_OUT(BUS_RDATA_OUT));

  // 40 ns core clock
  always #(rre_pkg::CLK_PERIOD_NS / 2) CLK_IN = ~CLK_IN;

  // closing report, the single exit of the run
  task automatic end_sim();
    $display("compares %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // case-equal compare, widened so one task serves every width
  task automatic chk(input string what, input logic [20:0] e, input logic [20:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // register offset to bus address, ram select bit low
  function automatic logic [12:0] ra(input logic [3:0] o);
    return {9'h000, o};
  endfunction : ra

  // one-cycle bus write
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge CLK_IN);
    BUS_ADDR_IN  <= a;
    BUS_WDATA_IN <= d;
    BUS_WR_IN    <= 1'b1;
    @(posedge CLK_IN);
    BUS_WR_IN    <= 1'b0;
  endtask : wr

  // one-cycle bus read, data only valid in the following clock
  task automatic rd(input string what, input logic [12:0] a, input logic [7:0] e);
    @(posedge CLK_IN);
    BUS_ADDR_IN <= a;
    BUS_RD_IN   <= 1'b1;
    @(posedge CLK_IN);
    BUS_RD_IN   <= 1'b0;
    @(negedge CLK_IN);
    chk(what, {13'h0000, e}, {13'h0000, BUS_RDATA_OUT});
  endtask : rd

  // offer an instruction until taken; returns just after the take edge
  task automatic issue(input logic [15:0] iw);
    int i;
    @(posedge CLK_IN);
    INSTR_IN       <= iw;
    INSTR_VALID_IN <= 1'b1;
    i = 0;
    do begin
      @(negedge CLK_IN);
      i++;
    end while (INSTR_READY_OUT !== 1'b1 && i < 16);
    if (INSTR_READY_OUT !== 1'b1) begin
      n_mismatch++;
      $display("wrong value ready expected 1 seen 0");
      end_sim();
    end
    @(posedge CLK_IN);
    INSTR_VALID_IN <= 1'b0;
  endtask : issue

  // a return with known registers, shadows and enable bits around it
  task automatic ret(input logic [15:0] iw, input logic [7:0] ic0, ew, es, eb, eic);
    logic [7:0] v [9];
    logic [20:0] top_val;
    v = '{8'h11, 8'h15, 8'h07, 8'h22, 8'h04, 8'h0A, ic0, 8'h33, 8'h44};
    for (int k = 0; k < 9; k++) wr(ra(k[3:0]), v[k]);
    top_val = {5'h00, iw} ^ 21'h1A5A5A;                       // differs per instruction
    STACK_TOP_IN <= top_val;
    issue(iw);
    repeat (2) @(negedge CLK_IN);
    chk("pop early", 21'h000000, {20'h00000, STACK_POP_OUT});
    @(negedge CLK_IN);
    chk("pop", 21'h000001, {20'h00000, STACK_POP_OUT});
    @(negedge CLK_IN);
    chk("pc load", 21'h000001, {20'h00000, PC_LOAD_OUT});
    chk("pc", top_val, PC_OUT);
    repeat (3) @(negedge CLK_IN);
    chk("flush ready", 21'h000000, {20'h00000, INSTR_READY_OUT});
    rd("working", ra(rre_pkg::REG_WORK), ew);
    rd("status", ra(rre_pkg::REG_STATUS), es);
    rd("bank", ra(rre_pkg::REG_BANK), eb);
    rd("enables", ra(rre_pkg::REG_INTCTL), eic);
    chk("high enable", {20'h00000, eic[0]}, {20'h00000, GLOBAL_HIGH_INT_ENABLE_OUT});
    chk("low enable", {20'h00000, eic[1]}, {20'h00000, PERIPHERAL_LOW_INT_ENABLE_OUT});
    rd("pc high", ra(rre_pkg::REG_PCHIGH), 8'h33);
    rd("pc upper", ra(rre_pkg::REG_PCUPPER), 8'h44);
    $display("return test %h done", iw);
  endtask : ret

  // rotate a file byte; expectations built from the operand and old carry
  task automatic rot(input logic d, a, input logic [7:0] f, v, input logic cin);
    logic [11:0] fa;
    logic [7:0]  res;
    logic [7:0]  st;
    fa  = a ? {4'h3, f} : (f < 8'h60 ? {4'h0, f} : {4'hF, f});
    res = {v[6:0], cin};
    st  = {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, v[7]};
    wr(ra(rre_pkg::REG_BANK), 8'h03);
    wr(ra(rre_pkg::REG_STATUS), {7'h00, cin});
    wr(ra(rre_pkg::REG_WORK), 8'h5A);
    wr({1'b1, fa}, v);
    issue({rre_pkg::OP_ROT, d, a, f});
    repeat (4) @(posedge CLK_IN);                             // one instruction cycle
    rd("file", {1'b1, fa}, d ? res : v);
    rd("working", ra(rre_pkg::REG_WORK), d ? 8'h5A : res);
    rd("status", ra(rre_pkg::REG_STATUS), st);
    $display("rotate test %h done", f);
  endtask : rot

  // main sequence
  initial begin
    repeat (20) @(posedge CLK_IN);
    chk("pc in reset", 21'h000000, PC_OUT);
    SYS_RST_IN <= 1'b0;
    rd("status reset", ra(rre_pkg::REG_STATUS), 8'h00);
    rd("unmapped", ra(4'hA), 8'h00);
    ret(rre_pkg::OP_RFI | 16'h0001, 8'h00, 8'h22, 8'h04, 8'h0A, 8'h01);
    ret(rre_pkg::OP_RFI, 8'h04, 8'h11, 8'h15, 8'h07, 8'h05);
    ret(rre_pkg::OP_RFI, 8'h05, 8'h11, 8'h15, 8'h07, 8'h07);
    ret(rre_pkg::OP_RSUB | 16'h0001, 8'h00, 8'h22, 8'h04, 8'h0A, 8'h00);
    ret(rre_pkg::OP_RSUB, 8'h00, 8'h11, 8'h15, 8'h07, 8'h00);
    ret({rre_pkg::OP_RLW, 8'hFF}, 8'h00, 8'hFF, 8'h15, 8'h07, 8'h00);
    ret({rre_pkg::OP_RLW, 8'h01}, 8'h00, 8'h01, 8'h15, 8'h07, 8'h00);
    rot(1'b1, 1'b1, 8'h21, 8'h80, 1'b1);
    rot(1'b0, 1'b0, 8'h70, 8'h80, 1'b0);
    rot(1'b1, 1'b0, 8'h10, 8'h40, 1'b0);
    rot(1'b0, 1'b1, 8'hFF, 8'hC3, 1'b1);
    end_sim();
  end
endmodule : return_and_rotate_exec_tb_top

// [rre_core_if.sv]
// interface: phase enables and file ram ports between the block's modules
`timescale 1ns/1ps
interface rre_core_if;
  logic [rre_pkg::Q_PER_CYCLE-1:0] q_en;    // one-hot phase enables
  logic [rre_pkg::FADDR_W-1:0]     a_addr;  // core port
  logic                            a_we;
  logic [rre_pkg::DATA_W-1:0]      a_wdata;
  logic [rre_pkg::DATA_W-1:0]      a_rdata;
  logic [rre_pkg::FADDR_W-1:0]     b_addr;  // software port
  logic                            b_we;
  logic [rre_pkg::DATA_W-1:0]      b_wdata;
  logic [rre_pkg::DATA_W-1:0]      b_rdata;
  modport qgen (output q_en);
  modport mem  (input a_addr, a_we, a_wdata, b_addr, b_we, b_wdata,
                output a_rdata, b_rdata);
  modport core (input q_en, a_rdata, b_rdata,
                output a_addr, a_we, a_wdata, b_addr, b_we, b_wdata);
endinterface : rre_core_if

// [rre_exec.sv]
// module: execution of the return and rotate-through-carry instructions
// Overview of operation
// - decode interrupt return, pop stack into pc
// - interrupt return sets the proper enable bit
// - interrupt return with flag restores shadows
// - literal return loads working, pops into pc
// - literal is low byte, eight bits
// - returns never touch the pc latches
// - decode subroutine return, pop, flags untouched without shadow flag
// - subroutine return with flag restores shadows
// - rotate left through carry, update n z
// - destination bit picks working or file
// - access bit picks access bank or bank
`timescale 1ns/1ps
module rre_exec (
  // clock and reset
  input  logic                         CLK_IN,
  input  logic                         SYS_RST_IN,
  // instruction issue
  input  logic                         INSTR_VALID_IN,
  input  logic [15:0]                  INSTR_IN,
  output logic                         INSTR_READY_OUT,
  // return stack
  input  logic [rre_pkg::PC_W-1:0]     STACK_TOP_IN,
  output logic                         STACK_POP_OUT,
  // program counter load
  output logic                         PC_LOAD_OUT,
  output logic [rre_pkg::PC_W-1:0]     PC_OUT,
  // interrupt enables
  output logic                         GLOBAL_HIGH_INT_ENABLE_OUT,
  output logic                         PERIPHERAL_LOW_INT_ENABLE_OUT,
  // register bus
  input  logic [rre_pkg::BUS_AW-1:0]   BUS_ADDR_IN,
  input  logic [rre_pkg::DATA_W-1:0]   BUS_WDATA_IN,
  input  logic                         BUS_WR_IN,
  input  logic                         BUS_RD_IN,
  output logic [rre_pkg::DATA_W-1:0]   BUS_RDATA_OUT
);
  // shared carrier and helpers
  rre_core_if core_if ();

  rre_qgen u_qgen (
    .CLK_IN     (CLK_IN),
    .SYS_RST_IN (SYS_RST_IN),
    .qif        (core_if)
  );

  rre_file_ram #(
    .DEPTH (2 ** rre_pkg::FADDR_W)
  ) u_ram (
    .CLK_IN     (CLK_IN),
    .SYS_RST_IN (SYS_RST_IN),
    .mif        (core_if)
  );

  // masked return opcode match, shadow flag ignored
  function automatic logic rre_ret_match(input logic [15:0] w, input logic [15:0] op);
    return (w & rre_pkg::OP_RET_MASK) == op;
  endfunction : rre_ret_match

  // register decode: low nibble offset, rest of the address zero
  function automatic logic rre_hit(input logic [rre_pkg::BUS_AW-1:0] a,
                                   input logic [3:0] off);
    return (a[rre_pkg::BUS_AW-1:4] == '0) && (a[3:0] == off);
  endfunction : rre_hit

  // state
  rre_pkg::rre_state_e          state_r;    // sequencer state
  rre_pkg::rre_state_e          state_nxt;
  logic [15:0]                  instr_r;    // instruction in execution
  logic [rre_pkg::DATA_W-1:0]   work_r;     // working register
  logic [rre_pkg::DATA_W-1:0]   status_r;   // status register
  logic [rre_pkg::BANK_W-1:0]   bank_r;     // bank select
  logic [rre_pkg::DATA_W-1:0]   wshad_r;    // working shadow
  logic [rre_pkg::DATA_W-1:0]   sshad_r;    // status shadow
  logic [rre_pkg::BANK_W-1:0]   bshad_r;    // bank select shadow
  logic [rre_pkg::DATA_W-1:0]   pch_r;      // pc high latch
  logic [rre_pkg::DATA_W-1:0]   pcu_r;      // pc upper latch
  logic                         hi_en_r;    // global / high enable
  logic                         lo_en_r;    // peripheral / low enable
  logic                         ipen_r;     // priority scheme on
  logic [rre_pkg::DATA_W-1:0]   rot_res_r;  // rotate result
  logic                         rot_cout_r; // carry out of rotate
  logic [rre_pkg::PC_W-1:0]     pc_r;       // loaded pc
  logic                         pc_load_r;  // pc load pulse
  logic [rre_pkg::DATA_W-1:0]   rdata_r;    // register read data
  logic                         ram_sel_r;  // read answered by ram

  // next values
  logic [rre_pkg::DATA_W-1:0]   work_nxt;
  logic [rre_pkg::DATA_W-1:0]   status_nxt;
  logic [rre_pkg::DATA_W-1:0]   rot_status;
  logic [rre_pkg::BANK_W-1:0]   bank_nxt;
  logic                         hi_en_nxt;
  logic                         lo_en_nxt;
  logic [rre_pkg::DATA_W-1:0]   reg_rd_val;

  // phase enables
  wire q1 = core_if.q_en[0];
  wire q2 = core_if.q_en[1];
  wire q3 = core_if.q_en[2];
  wire q4 = core_if.q_en[3];

  // instruction decode
  wire is_rfi  = rre_ret_match(instr_r, rre_pkg::OP_RFI);
  wire is_rsub = rre_ret_match(instr_r, rre_pkg::OP_RSUB);
  wire is_rlw  = instr_r[15:8] == rre_pkg::OP_RLW;
  wire is_rot  = instr_r[15:10] == rre_pkg::OP_ROT;
  wire is_ret  = is_rfi | is_rsub | is_rlw;
  wire shadow  = instr_r[rre_pkg::IW_SHADOW];
  wire dest    = instr_r[rre_pkg::IW_DEST];
  wire acc     = instr_r[rre_pkg::IW_ACC];
  wire [7:0] fsel    = instr_r[7:0];
  wire [7:0] literal = instr_r[7:0];

  // execution strobes, all at the last quarter
  wire exec      = state_r == rre_pkg::RRE_EXEC;
  wire ret_fire  = q4 & exec & is_ret;
  wire rot_fire  = q4 & exec & is_rot;
  wire rlw_fire  = q4 & exec & is_rlw;
  wire restore   = q4 & exec & (is_rfi | is_rsub) & shadow;
  wire rfi_fire  = q4 & exec & is_rfi;

  // which enable a return from interrupt sets
  wire set_high  = rfi_fire & (~ipen_r | ~hi_en_r);
  wire set_low   = rfi_fire & ipen_r & hi_en_r;

  // file address: banked or access bank split in low and high part
  wire [rre_pkg::BANK_W-1:0] acc_bank = (fsel < rre_pkg::ACC_SPLIT) ?
                                        rre_pkg::ACC_LO_BANK : rre_pkg::ACC_HI_BANK;
  wire [rre_pkg::FADDR_W-1:0] file_addr = acc ? {bank_r, fsel}
                                              : {acc_bank, fsel};

  // rotate left through carry from the fetched operand
  wire [rre_pkg::DATA_W-1:0] rot_calc = {core_if.a_rdata[6:0], status_r[rre_pkg::ST_C]};

  // bus decode
  wire bus_ram   = BUS_ADDR_IN[rre_pkg::RAM_SEL_BIT];
  wire reg_wr    = BUS_WR_IN & ~bus_ram;
  wire wr_work   = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_WORK);
  wire wr_status = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_STATUS);
  wire wr_bank   = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_BANK);
  wire wr_wshad  = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_WSHAD);
  wire wr_sshad  = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_SSHAD);
  wire wr_bshad  = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_BSHAD);
  wire wr_intctl = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_INTCTL);
  wire wr_pch    = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_PCHIGH);
  wire wr_pcu    = reg_wr & rre_hit(BUS_ADDR_IN, rre_pkg::REG_PCUPPER);

  // file ram ports: core at the operand, software on the other side
  assign core_if.a_addr  = file_addr;
  assign core_if.a_we    = rot_fire & dest;
  assign core_if.a_wdata = rot_res_r;
  assign core_if.b_addr  = BUS_ADDR_IN[rre_pkg::FADDR_W-1:0];
  assign core_if.b_we    = BUS_WR_IN & bus_ram;
  assign core_if.b_wdata = BUS_WDATA_IN;

  // working register: execution wins over a software write
  assign work_nxt = restore             ? wshad_r :
                    rlw_fire            ? literal :
                    (rot_fire & ~dest)  ? rot_res_r :
                    wr_work             ? BUS_WDATA_IN : work_r;

  // rotate flag update: carry, negative, zero
  always_comb begin
    rot_status               = status_r;
    rot_status[rre_pkg::ST_C] = rot_cout_r;
    rot_status[rre_pkg::ST_N] = rot_res_r[7];
    rot_status[rre_pkg::ST_Z] = rot_res_r == '0;
  end

  // status: plain returns leave it alone
  assign status_nxt = restore   ? sshad_r :
                      rot_fire  ? rot_status :
                      wr_status ? BUS_WDATA_IN : status_r;

  assign bank_nxt = restore ? bshad_r :
                    wr_bank ? BUS_WDATA_IN[rre_pkg::BANK_W-1:0] : bank_r;

  // hardware set beats a software clear in the same cycle
  assign hi_en_nxt = set_high | (wr_intctl ? BUS_WDATA_IN[rre_pkg::IC_HI_EN] : hi_en_r);
  assign lo_en_nxt = set_low  | (wr_intctl ? BUS_WDATA_IN[rre_pkg::IC_LO_EN] : lo_en_r);

  // sequencer: accept at first quarter, finish at last, returns add a flush cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rre_pkg::RRE_IDLE: begin
        if (q1 && INSTR_VALID_IN) begin
          state_nxt = rre_pkg::RRE_EXEC;
        end
      end
      rre_pkg::RRE_EXEC: begin
        if (q4) begin
          state_nxt = is_ret ? rre_pkg::RRE_FLUSH : rre_pkg::RRE_IDLE;
        end
      end
      rre_pkg::RRE_FLUSH: begin
        if (q4) begin
          state_nxt = rre_pkg::RRE_IDLE;
        end
      end
      default: state_nxt = rre_pkg::RRE_IDLE;
    endcase
  end

  // register read mux, unmapped offsets read zero
  always_comb begin
    reg_rd_val = rre_pkg::RST_BYTE;
    if (BUS_ADDR_IN[rre_pkg::BUS_AW-1:4] == '0) begin
      case (BUS_ADDR_IN[3:0])
        rre_pkg::REG_WORK:    reg_rd_val = work_r;
        rre_pkg::REG_STATUS:  reg_rd_val = status_r;
        rre_pkg::REG_BANK:    reg_rd_val = {4'h0, bank_r};
        rre_pkg::REG_WSHAD:   reg_rd_val = wshad_r;
        rre_pkg::REG_SSHAD:   reg_rd_val = sshad_r;
        rre_pkg::REG_BSHAD:   reg_rd_val = {4'h0, bshad_r};
        rre_pkg::REG_INTCTL:  reg_rd_val = {5'h00, ipen_r, lo_en_r, hi_en_r};
        rre_pkg::REG_PCHIGH:  reg_rd_val = pch_r;
        rre_pkg::REG_PCUPPER: reg_rd_val = pcu_r;
        rre_pkg::REG_EXEC:    reg_rd_val = {core_if.q_en, 2'h0, state_r};
        default:              reg_rd_val = rre_pkg::RST_BYTE;
      endcase
    end
  end

  // sequencer and instruction latch
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_r <= rre_pkg::RRE_IDLE;
      instr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (INSTR_READY_OUT && INSTR_VALID_IN) begin
        instr_r <= INSTR_IN;
      end
    end
  end

  // architectural registers
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      work_r   <= rre_pkg::RST_BYTE;
      status_r <= rre_pkg::RST_BYTE;
      bank_r   <= rre_pkg::RST_BANK;
      hi_en_r  <= 1'h0;
      lo_en_r  <= 1'h0;
      ipen_r   <= 1'h0;
    end else begin
      work_r   <= work_nxt;
      status_r <= status_nxt;
      bank_r   <= bank_nxt;
      hi_en_r  <= hi_en_nxt;
      lo_en_r  <= lo_en_nxt;
      if (wr_intctl) begin
        ipen_r <= BUS_WDATA_IN[rre_pkg::IC_IPEN];
      end
    end
  end

  // shadows and pc latches: software only, no return writes the latches
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wshad_r <= rre_pkg::RST_BYTE;
      sshad_r <= rre_pkg::RST_BYTE;
      bshad_r <= rre_pkg::RST_BANK;
      pch_r   <= rre_pkg::RST_BYTE;
      pcu_r   <= rre_pkg::RST_BYTE;
    end else begin
      if (wr_wshad) wshad_r <= BUS_WDATA_IN;
      if (wr_sshad) sshad_r <= BUS_WDATA_IN;
      if (wr_bshad) bshad_r <= BUS_WDATA_IN[rre_pkg::BANK_W-1:0];
      if (wr_pch)   pch_r   <= BUS_WDATA_IN;
      if (wr_pcu)   pcu_r   <= BUS_WDATA_IN;
    end
  end

  // rotate datapath: result captured at third quarter, operand read since second
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rot_res_r  <= rre_pkg::RST_BYTE;
      rot_cout_r <= 1'h0;
    end else if (q3 && exec && is_rot) begin
      rot_res_r  <= rot_calc;
      rot_cout_r <= core_if.a_rdata[7];
    end
  end

  // pc load from the popped top of stack
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pc_r      <= rre_pkg::RST_PC;
      pc_load_r <= 1'h0;
    end else begin
      pc_load_r <= ret_fire;
      if (ret_fire) begin
        pc_r <= STACK_TOP_IN;
      end
    end
  end

  // bus read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rdata_r   <= rre_pkg::RST_BYTE;
      ram_sel_r <= 1'h0;
    end else begin
      rdata_r   <= (BUS_RD_IN && !bus_ram) ? reg_rd_val : rre_pkg::RST_BYTE;
      ram_sel_r <= BUS_RD_IN & bus_ram;
    end
  end

  // outputs
  assign INSTR_READY_OUT  = q1 & (state_r == rre_pkg::RRE_IDLE);
  assign STACK_POP_OUT    = ret_fire;
  assign PC_LOAD_OUT      = pc_load_r;
  assign PC_OUT           = pc_r;
  assign GLOBAL_HIGH_INT_ENABLE_OUT    = hi_en_r;
  assign PERIPHERAL_LOW_INT_ENABLE_OUT = lo_en_r;
  assign BUS_RDATA_OUT    = ram_sel_r ? core_if.b_rdata : rdata_r;

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_ret_end;
    q4 && exec && is_ret;
  endsequence

  sequence s_rot_wr_w;
    q3 && exec && is_rot && !dest ##1 !wr_work;
  endsequence

  a_ret_pop_pc: assert property (s_ret_end |-> STACK_POP_OUT ##1
    (PC_LOAD_OUT && PC_OUT == $past(STACK_TOP_IN)))
    else $error("return did not pop into pc");
  a_rfi_enable: assert property (rfi_fire && !ipen_r |=> hi_en_r)
    else $error("interrupt return left enable clear");
  a_shadow_copy: assert property (restore |=> work_r == $past(wshad_r)
    && status_r == $past(sshad_r) && bank_r == $past(bshad_r))
    else $error("shadow restore failed");
  a_literal_load: assert property (rlw_fire |=> work_r == $past(instr_r[7:0]))
    else $error("literal not loaded");
  a_latch_kept: assert property (s_ret_end ##0 (!wr_pch && !wr_pcu) |=>
    $stable(pch_r) && $stable(pcu_r))
    else $error("pc latch changed by return");
  a_noshadow_keep: assert property (q4 && exec && (is_rfi || is_rsub) && !shadow
    && !wr_work && !wr_status && !wr_bank |=> $stable(work_r) && $stable(status_r)
    && $stable(bank_r))
    else $error("registers changed without shadow flag");
  a_rot_to_work: assert property (s_rot_wr_w |=>
    work_r == {$past(core_if.a_rdata[6:0], 2), $past(status_r[rre_pkg::ST_C], 2)})
    else $error("rotate result wrong");
  a_rot_to_file: assert property (q4 && exec && is_rot |-> core_if.a_we == dest)
    else $error("rotate destination wrong");
  a_access_bank: assert property (q2 && exec && is_rot && !acc && fsel <
    rre_pkg::ACC_SPLIT |-> core_if.a_addr[11:8] == rre_pkg::ACC_LO_BANK)
    else $error("access bank address wrong");
  a_ret_flush: assert property (s_ret_end |=> !INSTR_READY_OUT [*4] ##1
    INSTR_READY_OUT)
    else $error("return flush cycle wrong");
  a_rot_single: assert property (q4 && exec && is_rot |=> INSTR_READY_OUT)
    else $error("rotate took more than one cycle");
endmodule : rre_exec

// [rre_file_ram.sv]
// module: dual port file register memory with registered read data
`timescale 1ns/1ps
module rre_file_ram #(
  parameter int DEPTH = 2 ** rre_pkg::FADDR_W  // words held
) (
  // clock and reset
  input  logic     CLK_IN,
  input  logic     SYS_RST_IN,
  // memory ports
  rre_core_if.mem  mif
);
  logic [rre_pkg::DATA_W-1:0] mem [DEPTH];  // storage, not reset

  // writes; core port listed last so it wins a same-address clash
  always_ff @(posedge CLK_IN) begin
    if (mif.b_we) begin
      mem[mif.b_addr] <= mif.b_wdata;
    end
    if (mif.a_we) begin
      mem[mif.a_addr] <= mif.a_wdata;
    end
  end

  // registered reads on both ports, old data on a write
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mif.a_rdata <= rre_pkg::RST_BYTE;
      mif.b_rdata <= rre_pkg::RST_BYTE;
    end else begin
      mif.a_rdata <= mem[mif.a_addr];
      mif.b_rdata <= mem[mif.b_addr];
    end
  end
endmodule : rre_file_ram

// [rre_pkg.sv]
// package: constants, offsets and types of the return and rotate execution block
package rre_pkg;
  localparam int PC_W        = 21;               // program counter width
  localparam int DATA_W      = 8;                // data path width
  localparam int FADDR_W     = 12;               // file register address width
  localparam int BANK_W      = 4;                // bank select width
  localparam int BUS_AW      = 13;               // register bus address width
  localparam int RAM_SEL_BIT = 12;               // bus address bit picking the file ram
  localparam int Q_PER_CYCLE = 4;                // clocks per instruction cycle
  localparam int CLK_PERIOD_NS = 40;             // core clock period
  // opcode patterns
  localparam logic [15:0] OP_RET_MASK = 16'hFFFE; // hides the shadow flag
  localparam logic [15:0] OP_RFI      = 16'h0010; // return from interrupt
  localparam logic [15:0] OP_RSUB     = 16'h0012; // return from subroutine
  localparam logic [7:0]  OP_RLW      = 8'h0C;    // return with literal, high byte
  localparam logic [5:0]  OP_ROT      = 6'h0D;    // rotate through carry, bits 15:10
  // instruction word fields
  localparam int IW_SHADOW = 0;
  localparam int IW_ACC    = 8;
  localparam int IW_DEST   = 9;
  // status bits
  localparam int ST_C = 0;
  localparam int ST_Z = 2;
  localparam int ST_N = 4;
  // interrupt control bits
  localparam int IC_HI_EN = 0;                   // global / high priority enable
  localparam int IC_LO_EN = 1;                   // peripheral / low priority enable
  localparam int IC_IPEN = 2;
  // access bank split
  localparam logic [7:0]        ACC_SPLIT   = 8'h60;
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;
  // register offsets
  localparam logic [3:0] REG_WORK    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_BANK    = 4'h2;
  localparam logic [3:0] REG_WSHAD   = 4'h3;
  localparam logic [3:0] REG_SSHAD   = 4'h4;
  localparam logic [3:0] REG_BSHAD   = 4'h5;
  localparam logic [3:0] REG_INTCTL  = 4'h6;
  localparam logic [3:0] REG_PCHIGH  = 4'h7;
  localparam logic [3:0] REG_PCUPPER = 4'h8;
  localparam logic [3:0] REG_EXEC    = 4'h9;
  // reset values
  localparam logic [7:0]        RST_BYTE = 8'h00;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
  localparam logic [PC_W-1:0]   RST_PC   = 21'h000000;
  // sequencer states
  typedef enum logic [1:0] {
    RRE_IDLE  = 2'b00,
    RRE_EXEC  = 2'b01,
    RRE_FLUSH = 2'b10
  } rre_state_e;
endpackage : rre_pkg

// [rre_qgen.sv]
// module: phase divider giving one-cycle enables for each quarter of an instruction cycle
`timescale 1ns/1ps
module rre_qgen (
  // clock and reset
  input  logic       CLK_IN,
  input  logic       SYS_RST_IN,
  // phase enables
  rre_core_if.qgen   qif
);
  logic [1:0] phase_r;  // current quarter

  // free running quarter counter, first quarter right after reset
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // one enable per quarter
  for (genvar gi = 0; gi < rre_pkg::Q_PER_CYCLE; gi++) begin : g_q
    assign qif.q_en[gi] = (phase_r == 2'(gi));
  end
endmodule : rre_qgen
